/* verilog/tcc_timer16.v */
// 16-bit free-running timer with compare, toggle output and capture
// assumes: cpu byte bus synchronous to i_clk, capture pin asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_timer16 (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_cpu_fall_en,
  input  wire [15:0] i_addr,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  input  wire        i_port_latch,
  input  wire        i_capture_input_pin,
  input  wire        i_shared_timer_pin,
  output wire        o_shared_timer_pin,
  output wire        o_shared_timer_pin_oen,
  output reg         o_match_interrupt_request
);

  reg  [7:0]  port5_pin_direction_reg;
  reg  [7:0]  timer_control_reg;
  reg  [15:0] compare_value_reg;
  reg  [15:0] free_counter_reg;
  reg  [15:0] capture_value_reg;
  reg  [5:0]  prescale_reg;
  reg         timer_output_signal_reg;
  reg         cap_meta_reg;
  reg         cap_sync_reg;
  reg         cap_prev_reg;
  reg         cap_event_reg;
  reg  [15:0] cap_count_reg;
  reg         out_en_d_reg;
  reg         pin_sync1_reg;
  reg         pin_sync2_reg;
  wire        count_en;
  wire        match;
  wire [1:0]  edge_sel;
  wire        rise;
  wire        fall;
  wire        cap_hit;
  wire        rd_cnt_lo;
  wire        rd_cnt_hi;
  wire [15:0] buf_value;
  wire        ctl_wr;

  function addr_is;
    input [15:0] a;
    input [15:0] b;
    begin
      addr_is = (a == b);
    end
  endfunction

  assign ctl_wr    = i_wr && addr_is(i_addr, `TCC_ADDR_CONTROL);
  assign rd_cnt_lo = i_rd && addr_is(i_addr, `TCC_ADDR_CNT_LO);
  assign rd_cnt_hi = i_rd && addr_is(i_addr, `TCC_ADDR_CNT_HI);

  // ****************************************************************
  // prescaler and counter
  // ****************************************************************
  // prohibited clock codes fall back to the slow rate, never stall
  assign count_en = (timer_control_reg[`TCC_BIT_CLK_HI:`TCC_BIT_CLK_LO]
                     == `TCC_CLKSEL_FAST)
                    ? (prescale_reg[`TCC_DIV_SHIFT_FAST-1:0] == 2'h3)
                    : (prescale_reg == 6'h3F);

  assign match = (free_counter_reg == compare_value_reg);

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      prescale_reg     <= 6'h00;
      free_counter_reg <= `TCC_RST_CNT;
    end else begin
      // no stop mode here: counting never pauses, so no settling gap
      prescale_reg     <= prescale_reg + 6'h01;
      if (count_en) begin
        free_counter_reg <= free_counter_reg + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // match, output toggle, overflow flag and control register
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_match_interrupt_request <= 1'b0;
      out_en_d_reg              <= 1'b0;
      timer_output_signal_reg   <= 1'b0;
      timer_control_reg         <= `TCC_RST_CONTROL;
    end else begin
      // one pulse per count clock period that holds the match
      o_match_interrupt_request <= match && count_en;
      out_en_d_reg <= timer_control_reg[`TCC_BIT_OUT_EN];
      if (timer_control_reg[`TCC_BIT_OUT_EN] && !out_en_d_reg) begin
        timer_output_signal_reg <= 1'b0;
      end else if (match && count_en &&
                   timer_control_reg[`TCC_BIT_INV_EN]) begin
        timer_output_signal_reg <= ~timer_output_signal_reg;
      end
      if (ctl_wr) begin
        timer_control_reg[5:0] <= i_wdata[5:0];
      end
      // overflow set beats a software clear in the same cycle
      if (count_en && free_counter_reg == 16'hFFFF) begin
        timer_control_reg[`TCC_BIT_OVF] <= 1'b1;
      end else if (ctl_wr) begin
        timer_control_reg[`TCC_BIT_OVF] <= i_wdata[`TCC_BIT_OVF];
      end
      timer_control_reg[`TCC_BIT_OUT_DATA] <= timer_output_signal_reg;
    end
  end

  // ****************************************************************
  // compare and direction registers
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      compare_value_reg       <= `TCC_RST_CMP;
      port5_pin_direction_reg <= `TCC_RST_PIN_DIR;
    end else begin
      if (i_wr && addr_is(i_addr, `TCC_ADDR_CMP_LO)) begin
        compare_value_reg[7:0] <= i_wdata;
      end
      if (i_wr && addr_is(i_addr, `TCC_ADDR_CMP_HI)) begin
        compare_value_reg[15:8] <= i_wdata;
      end
      if (i_wr && addr_is(i_addr, `TCC_ADDR_PIN_DIR)) begin
        // upper four bits are fixed at one
        port5_pin_direction_reg <= {4'hF, i_wdata[3:0]};
      end
    end
  end

  // ****************************************************************
  // shared pin: timer signal or port latch, oen low drives
  // ****************************************************************
  assign o_shared_timer_pin = timer_control_reg[`TCC_BIT_OUT_EN]
                              ? timer_output_signal_reg
                              : i_port_latch;
  assign o_shared_timer_pin_oen =
    port5_pin_direction_reg[`TCC_BIT_SHARED_PIN];

  // ****************************************************************
  // capture path
  // ****************************************************************
  assign edge_sel = timer_control_reg[`TCC_BIT_CAP_HI:`TCC_BIT_CAP_LO];
  assign rise     = cap_sync_reg && !cap_prev_reg;
  assign fall     = !cap_sync_reg && cap_prev_reg;
  assign cap_hit  = ((edge_sel == `TCC_EDGE_RISE) && rise) ||
                    ((edge_sel == `TCC_EDGE_FALL) && fall) ||
                    ((edge_sel == `TCC_EDGE_BOTH) && (rise || fall));

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cap_meta_reg      <= 1'b0;
      cap_sync_reg      <= 1'b0;
      cap_prev_reg      <= 1'b0;
      cap_event_reg     <= 1'b0;
      cap_count_reg     <= `TCC_RST_CNT;
      capture_value_reg <= `TCC_RST_CNT;
      pin_sync1_reg     <= 1'b0;
      pin_sync2_reg     <= 1'b0;
    end else begin
      cap_meta_reg  <= i_capture_input_pin;
      cap_sync_reg  <= cap_meta_reg;
      cap_prev_reg  <= cap_sync_reg;
      pin_sync1_reg <= i_shared_timer_pin;
      pin_sync2_reg <= pin_sync1_reg;
      // count is caught at the edge, stored one clock later
      cap_event_reg <= cap_hit;
      if (cap_hit) begin
        cap_count_reg <= free_counter_reg;
      end
      if (cap_event_reg) begin
        capture_value_reg <= cap_count_reg;
      end
    end
  end

  // ****************************************************************
  // counter read buffer and read data
  // ****************************************************************
  tcc_read_buffer i_tcc_read_buffer (
    .i_clk         (i_clk),
    .i_rstn        (i_rstn),
    .i_cpu_fall_en (i_cpu_fall_en),
    .i_rd_lo       (rd_cnt_lo),
    .i_rd_hi       (rd_cnt_hi),
    .i_count       (free_counter_reg),
    .o_value       (buf_value),
    .o_frozen      ()
  );

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= o_rdata;
    end else if (addr_is(i_addr, `TCC_ADDR_PIN_DIR)) begin
      o_rdata <= port5_pin_direction_reg;
    end else if (addr_is(i_addr, `TCC_ADDR_CONTROL)) begin
      o_rdata <= timer_control_reg;
    end else if (addr_is(i_addr, `TCC_ADDR_CMP_LO)) begin
      o_rdata <= compare_value_reg[7:0];
    end else if (addr_is(i_addr, `TCC_ADDR_CMP_HI)) begin
      o_rdata <= compare_value_reg[15:8];
    end else if (addr_is(i_addr, `TCC_ADDR_CNT_LO)) begin
      o_rdata <= buf_value[7:0];
    end else if (addr_is(i_addr, `TCC_ADDR_CNT_HI)) begin
      o_rdata <= buf_value[15:8];
    end else if (addr_is(i_addr, `TCC_ADDR_CAP_LO)) begin
      o_rdata <= capture_value_reg[7:0];
    end else if (addr_is(i_addr, `TCC_ADDR_CAP_HI)) begin
      o_rdata <= capture_value_reg[15:8];
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* verilog/tcc_defs.vh */
// register offsets, field positions, reset values and timing counts
// assumes: included by the timer design files and by the checker and bench
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ****************************************************************
// register map (byte addresses in the special function area)
// ****************************************************************
`define TCC_ADDR_PIN_DIR     16'hFF25
`define TCC_ADDR_CONTROL     16'hFF5B
`define TCC_ADDR_CMP_LO      16'hFF5C
`define TCC_ADDR_CMP_HI      16'hFF5D
`define TCC_ADDR_CNT_LO      16'hFF5E
`define TCC_ADDR_CNT_HI      16'hFF5F
`define TCC_ADDR_CAP_LO      16'hFF60
`define TCC_ADDR_CAP_HI      16'hFF61

// ****************************************************************
// reset values
// ****************************************************************
`define TCC_RST_PIN_DIR      8'hFF
`define TCC_RST_CONTROL      8'h00
`define TCC_RST_CMP          16'hFFFF
`define TCC_RST_CNT          16'h0000

// ****************************************************************
// timer control field positions and the shared pin direction bit
// ****************************************************************
`define TCC_BIT_OUT_DATA     7
`define TCC_BIT_OVF          6
`define TCC_BIT_CAP_HI       5
`define TCC_BIT_CAP_LO       4
`define TCC_BIT_INV_EN       3
`define TCC_BIT_CLK_HI       2
`define TCC_BIT_CLK_LO       1
`define TCC_BIT_OUT_EN       0
`define TCC_BIT_SHARED_PIN   1

// ****************************************************************
// count clock: system clock divided by 2^2 or 2^6
// ****************************************************************
`define TCC_DIV_SHIFT_FAST   2
`define TCC_DIV_SHIFT_SLOW   6
`define TCC_CLKSEL_FAST      2'h0
`define TCC_CLKSEL_SLOW      2'h1

// capture edge codes
`define TCC_EDGE_NONE        2'h0
`define TCC_EDGE_RISE        2'h1
`define TCC_EDGE_FALL        2'h2
`define TCC_EDGE_BOTH        2'h3

`endif

/* verilog/tcc_read_buffer.v */
// counter read buffer: follows the counter, freezes for a byte pair
// assumes: read strobes are synchronous to i_clk, cpu clock falls
// are given as a one-cycle enable i_cpu_fall_en
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_read_buffer (
  input  wire        i_clk,
  input  wire        i_rstn,
  input  wire        i_cpu_fall_en,
  input  wire        i_rd_lo,
  input  wire        i_rd_hi,
  input  wire [15:0] i_count,
  output reg  [15:0] o_value,
  output reg         o_frozen
);

  reg rd_lo_d_reg;
  reg rd_hi_d_reg;
  reg freeze_pend_reg;
  reg thaw_pend_reg;

  // ****************************************************************
  // strobe edges are latched until the next cpu clock fall
  // ****************************************************************
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      rd_lo_d_reg     <= 1'b0;
      rd_hi_d_reg     <= 1'b0;
      freeze_pend_reg <= 1'b0;
      thaw_pend_reg   <= 1'b0;
      o_frozen        <= 1'b0;
      o_value         <= `TCC_RST_CNT;
    end else begin
      rd_lo_d_reg <= i_rd_lo;
      rd_hi_d_reg <= i_rd_hi;
      if (i_rd_lo && !rd_lo_d_reg) begin
        freeze_pend_reg <= 1'b1;
      end else if (i_cpu_fall_en) begin
        freeze_pend_reg <= 1'b0;
      end
      if (!i_rd_hi && rd_hi_d_reg) begin
        thaw_pend_reg <= 1'b1;
      end else if (i_cpu_fall_en) begin
        thaw_pend_reg <= 1'b0;
      end
      if (i_cpu_fall_en && freeze_pend_reg) begin
        o_frozen <= 1'b1;
      end else if (i_cpu_fall_en && thaw_pend_reg) begin
        o_frozen <= 1'b0;
      end
      // tracking stops at the low-byte strobe, so both bytes share one value
      if (!o_frozen && !freeze_pend_reg && !(i_rd_lo && !rd_lo_d_reg)) begin
        o_value <= i_count;
      end
    end
  end

endmodule

`default_nettype wire

/* test/tcc_pin_model.sv */
// model of the pins around the timer: capture source and shared pin
// assumes: the bench commands capture levels; shared pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input  wire logic i_clk,
  input  wire logic i_pin_out,
  input  wire logic i_pin_oen,
  input  wire logic i_cap_cmd,
  output var  logic o_cap_pin,
  output wire logic o_pin_level
);
  // ****************************************************************
  // pin levels
  // ****************************************************************
  initial o_cap_pin = 1'b0;
  // edges move after a clock edge, never on the sampling instant
  always @(posedge i_clk) o_cap_pin <= #1 i_cap_cmd;
  // a released pin floats up through its pull-up
  assign o_pin_level = i_pin_oen ? 1'b1 : i_pin_out;
endmodule
`default_nettype wire

/* test/tcc_timer16_checker.sv */
// assertions on the ports of the 16-bit timer
// assumes: bound to every instance of the timer top module
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
module tcc_timer16_checker (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [15:0] i_addr,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_port_latch,
  input wire logic        o_shared_timer_pin,
  input wire logic        o_shared_timer_pin_oen,
  input wire logic        o_match_interrupt_request
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_dir_wr;
    i_wr && i_addr == `TCC_ADDR_PIN_DIR;
  endsequence
  sequence s_dir_rd;
    i_rd && !i_wr && i_addr == `TCC_ADDR_PIN_DIR;
  endsequence
  property p_rst;
    $rose(i_rstn) |-> o_shared_timer_pin_oen && !o_match_interrupt_request
      && o_shared_timer_pin == i_port_latch;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_dir_out;
    s_dir_wr ##0 !i_wdata[1] |=> !o_shared_timer_pin_oen;
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("pin not driven");
  property p_dir_in;
    s_dir_wr ##0 i_wdata[1] |=> o_shared_timer_pin_oen;
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("pin not released");
  property p_dir_oen;
    s_dir_rd |=> o_rdata[1] == o_shared_timer_pin_oen;
  endproperty
  a_dir_oen: assert property (p_dir_oen) else $error("dir bit vs enable");
  property p_dir_hi;
    s_dir_rd |=> o_rdata[7:4] == 4'hF;
  endproperty
  a_dir_hi: assert property (p_dir_hi) else $error("dir upper bits");
  // match pulses are at least one count clock apart, i.e. 4 cycles
  property p_irq_gap;
    o_match_interrupt_request |=> !o_match_interrupt_request [*3];
  endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("match too close");
  property p_toggle;
    $changed(o_shared_timer_pin) && $past(i_rstn) && !$past(i_wr)
      && $stable(i_port_latch) |-> o_match_interrupt_request;
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin moved alone");
  property p_rd_hold;
    !i_rd |=> $stable(o_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind tcc_timer16 tcc_timer16_checker i_tcc_timer16_checker (.i_clk, .i_rstn,
  .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_port_latch,
  .o_shared_timer_pin, .o_shared_timer_pin_oen, .o_match_interrupt_request);
`default_nettype wire

/* test/tcc_timer16_tb.sv */
// self-checking bench for the 16-bit timer
// assumes: the pin model stands on the capture and shared pins
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tcc_timer16_tb;
  // ****************************************************************
  // stimulus and design
  // ****************************************************************
  logic        i_clk = 0, i_rstn = 0, fall = 0, wr = 0, rd = 0, cap = 0;
  logic [15:0] addr = 16'h0000, v, w, c0, c1, c2;
  logic [7:0]  wdat = 8'h00, rdat;
  wire  [7:0]  rdata;
  wire         pout, poen, irq, cap_pin, lvl;
  int          num_errors = 0, tests_run = 0;
  tcc_timer16 i_tcc_timer16 (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_cpu_fall_en(fall), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdat), .o_rdata(rdata), .i_port_latch(1'b0),
    .i_capture_input_pin(cap_pin), .i_shared_timer_pin(lvl),
    .o_shared_timer_pin(pout), .o_shared_timer_pin_oen(poen),
    .o_match_interrupt_request(irq));
  tcc_pin_model i_tcc_pin_model (.i_clk(i_clk), .i_pin_out(pout),
    .i_pin_oen(poen), .i_cap_cmd(cap), .o_cap_pin(cap_pin),
    .o_pin_level(lvl));
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) fall <= #1 ~fall;
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    wr = 1; addr = a; wdat = d;
    @(posedge i_clk) #1;
    wr = 0;
  endtask
  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    rd = 1; addr = a;
    @(posedge i_clk) #1;
    rd = 0; d = rdata;
  endtask
  // low byte first, then high byte, always as a pair
  task automatic r16(input logic [15:0] a, output logic [15:0] d);
    rreg(a, d[7:0]);
    rreg(a + 16'h0001, d[15:8]);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rreg(`TCC_ADDR_PIN_DIR, rdat); `CHK("dir", `TCC_RST_PIN_DIR, rdat)
    rreg(`TCC_ADDR_CONTROL, rdat); `CHK("ctl", `TCC_RST_CONTROL, rdat)
    r16(`TCC_ADDR_CMP_LO, v); `CHK("cmp", `TCC_RST_CMP, v)
    r16(`TCC_ADDR_CNT_LO, v); `CHK("cnt hi", 8'h00, v[15:8])
    `CHK("cnt runs", 1'b1, v != 16'h0000)
    `CHK("oen", 1'b1, poen)
    rreg(16'hFFFF, rdat); `CHK("unmapped", 8'h00, rdat)
    $display("test reset done");
  endtask
  task automatic t_match;
    int k;
    wreg(`TCC_ADDR_PIN_DIR, 8'hFD);
    @(posedge i_clk) #1;
    `CHK("pin drive", 1'b0, poen)
    r16(`TCC_ADDR_CNT_LO, v);
    w = v + 16'h0020;
    // inversion still off while the compare value changes
    wreg(`TCC_ADDR_CMP_LO, w[7:0]);
    wreg(`TCC_ADDR_CMP_HI, w[15:8]);
    wreg(`TCC_ADDR_CONTROL, 8'h19);
    `CHK("start low", 1'b0, pout)
    for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge i_clk) #1;
    `CHK("match", 1'b1, irq)
    `CHK("toggle", 1'b1, lvl)
    r16(`TCC_ADDR_CNT_LO, v);
    `CHK("no clear", 1'b1, v - w < 16'h0010)
    $display("test match done");
  endtask
  task automatic t_clock;
    int k;
    logic [15:0] d, e;
    for (k = 0; k < 2; k++) begin
      wreg(`TCC_ADDR_CONTROL, {5'h00, k[0], 2'b00});
      @(posedge i_clk) #1;
      `CHK("port mode", 1'b0, pout)
      r16(`TCC_ADDR_CNT_LO, v);
      repeat (640) @(posedge i_clk);
      r16(`TCC_ADDR_CNT_LO, w);
      d = w - v;
      e = k ? 16'h000A : 16'h00A1;
      `CHK("rate", 1'b1, d >= e - 16'h0001 && d <= e + 16'h0001)
    end
    $display("test clock done");
  endtask
  // the pin only moves between capture reads, never during one
  task automatic t_capture;
    int k;
    for (k = 0; k < 4; k++) begin
      wreg(`TCC_ADDR_CONTROL, {2'b00, k[1:0], 4'h0});
      r16(`TCC_ADDR_CAP_LO, c0);
      cap = 1;
      repeat (8) @(posedge i_clk);
      r16(`TCC_ADDR_CAP_LO, c1);
      cap = 0;
      repeat (8) @(posedge i_clk);
      r16(`TCC_ADDR_CAP_LO, c2);
      `CHK("rise", k[0], c1 !== c0)
      `CHK("fall", k[1], c2 !== c1)
    end
    $display("test capture done");
  endtask
  task automatic t_freeze;
    rreg(`TCC_ADDR_CNT_LO, v[7:0]);
    repeat (40) @(posedge i_clk);
    rreg(`TCC_ADDR_CNT_LO, w[7:0]);
    repeat (40) @(posedge i_clk);
    rreg(`TCC_ADDR_CNT_LO, c0[7:0]);
    `CHK("frozen", w[7:0], c0[7:0])
    `CHK("frozen first", v[7:0], w[7:0])
    rreg(`TCC_ADDR_CNT_HI, v[15:8]);
    repeat (40) @(posedge i_clk);
    r16(`TCC_ADDR_CNT_LO, c1);
    `CHK("released", 1'b1, c1[7:0] !== c0[7:0])
    $display("test freeze done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_rstn = 1;
    t_reset;
    t_match;
    t_clock;
    t_capture;
    t_freeze;
    final_report;
  end
  initial begin
    #2000000;
    num_errors++;
    final_report;
  end
endmodule
`default_nettype wire
